// *** common/mci_defines.vh ***
// Constants of the monitor control and interrupt status block.
// Included by the design file; holds definitions only.
`ifndef MCI_DEFINES_VH
`define MCI_DEFINES_VH

// Register offsets
`define MCI_ADDR_CFG1        8'h40
`define MCI_ADDR_STAT1       8'h41
`define MCI_ADDR_STAT2       8'h42
`define MCI_ADDR_MASK1       8'h43

// Reset values
`define MCI_RST_CFG1         8'h08
`define MCI_RST_STAT1        8'h00
`define MCI_RST_STAT2        8'h00
`define MCI_RST_MASK1        8'h00

// Configuration field positions
`define MCI_CFG_START        0
`define MCI_CFG_INT_EN       1
`define MCI_CFG_THERMAL_ALARM_PIN_EN     2
`define MCI_CFG_INT_CLR      3
`define MCI_CFG_RST_PULSE    4
`define MCI_CFG_RSVD         5
`define MCI_CFG_THERMAL_ALARM_PIN_REL    6
`define MCI_CFG_INIT         7

// Status two field positions
`define MCI_ST2_12V          0
`define MCI_ST2_CORE_TWO     1
`define MCI_ST2_CHASSIS      4
`define MCI_ST2_THERMAL_ALARM_PIN_EXT    5
`define MCI_ST2_DIODE_ONE    6
`define MCI_ST2_DIODE_TWO    7
// Bits 2 and 3 are undefined and read as zero
`define MCI_ST2_IMPL_MASK    8'hf3

// Timing
`define MCI_CLK_KHZ          250000
`define MCI_RST_PULSE_MS     45
`define MCI_RST_PULSE_CYC    (`MCI_RST_PULSE_MS * `MCI_CLK_KHZ)

`endif

// *** rtl/mci_top.v ***
// Control register, interrupt status and mask logic of a hardware monitor.
// Assumes a register access port driven by the serial bus engine on i_clk,
// and event strobes from the measurement engine on the same clock.
//
// Overview of operation
// - Control bit 0 set runs scanning and limit checks; clear means standby.
// - Clearing the start bit does not release an asserted interrupt output.
// - Control bit 1 enables the active-low interrupt output; resets to 0.
// - Control bit 3 deasserts the interrupt output, status contents kept.
// - While control bit 3 is set monitoring pauses; resumes when cleared.
// - Writing control bit 4 gives a 45 ms low pulse on reset output, self-clearing.
// - Writing control bit 6 releases the thermal alarm output, status kept.
// - Writing control bit 7 restores power-on values, then clears itself.
// - Status one bit sets when its channel's high or low limit is exceeded.
// - Temperature status bits also set on a temperature interrupt condition.
// - Status two bit 0 flags 12 V, bit 1 core voltage two violation.
// - Status two bit 4 sets when chassis intrusion input goes high.
// - Status two bit 5 sets when something else pulls thermal alarm low.
// - Status two bits 6 and 7 flag diode one and two faults.
// - Reading a status register clears the bits that the read returned.
// - Unserviced out-of-limit channels raise a new indication automatically.
// - Mask one bits set stop matching status one bits reaching the interrupt.
`include "mci_defines.vh"

module mci_top #(
    parameter [31:0] RST_PULSE_CYC = `MCI_RST_PULSE_CYC
) (
    // Clock and reset
    input  wire       i_clk,
    input  wire       i_rstn,
    // Register access port
    input  wire       i_reg_wr,
    input  wire       i_reg_rd,
    input  wire [7:0] i_reg_addr,
    input  wire [7:0] i_reg_wdata,
    output reg  [7:0] o_reg_rdata,
    output reg        o_reg_rvalid,
    // Measurement engine events
    input  wire [7:0] i_limit_one,
    input  wire [1:0] i_temp_event,
    input  wire       i_limit_12v,
    input  wire       i_limit_core_voltage_two,
    input  wire       i_diode_one_fault,
    input  wire       i_diode_two_fault,
    input  wire       i_over_temp,
    // Measurement engine control
    output reg        o_monitor_run,
    output reg        o_init_pulse,
    // Pins
    input  wire       i_chassis_pin,
    input  wire       i_thermal_alarm_pin_i,
    output reg        o_thermal_alarm_pin_o,
    output reg        o_thermal_alarm_pin_oe,
    output reg        o_int_n,
    output reg        o_reset_pin_n
);

    reg  [7:0]  cfg_q;
    reg  [7:0]  stat1_q;
    reg  [7:0]  stat2_q;
    reg  [7:0]  mask1_q;
    reg  [23:0] rst_cnt_q;
    reg  [1:0]  chassis_sync_q;
    reg         chassis_prev_q;
    reg  [1:0]  thermal_alarm_pin_sync_q;
    reg  [2:0]  drive_hist_q;

    wire wr_cfg   = i_reg_wr && (i_reg_addr == `MCI_ADDR_CFG1);
    wire wr_mask1 = i_reg_wr && (i_reg_addr == `MCI_ADDR_MASK1);
    wire rd_stat1 = i_reg_rd && (i_reg_addr == `MCI_ADDR_STAT1);
    wire rd_stat2 = i_reg_rd && (i_reg_addr == `MCI_ADDR_STAT2);
    wire do_init  = wr_cfg && i_reg_wdata[`MCI_CFG_INIT];

    // Engine events only count while monitoring runs
    wire running  = cfg_q[`MCI_CFG_START] && !cfg_q[`MCI_CFG_INT_CLR];

    wire [7:0] ev1;
    wire [7:0] ev2;
    wire       chassis_rise;
    wire       thermal_alarm_pin_ext_low;

    assign ev1 = running ? (i_limit_one | {2'b00, i_temp_event, 4'h0}) : 8'h00;

    assign chassis_rise = chassis_sync_q[1] && !chassis_prev_q;
    // Pin low while we have not driven it over the synchroniser latency
    assign thermal_alarm_pin_ext_low = !thermal_alarm_pin_sync_q[1] && (drive_hist_q == 3'b000);

    assign ev2 = ({i_diode_two_fault, i_diode_one_fault, 4'h0,
                   i_limit_core_voltage_two, i_limit_12v} & {8{running}})
               | ({2'b00, thermal_alarm_pin_ext_low, chassis_rise, 4'h0});

    // Pin synchronisers
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            chassis_sync_q <= 2'b00;
            chassis_prev_q <= 1'b0;
            thermal_alarm_pin_sync_q   <= 2'b11;
            drive_hist_q   <= 3'b000;
        end else begin
            chassis_sync_q <= {chassis_sync_q[0], i_chassis_pin};
            chassis_prev_q <= chassis_sync_q[1];
            thermal_alarm_pin_sync_q   <= {thermal_alarm_pin_sync_q[0], i_thermal_alarm_pin_i};
            drive_hist_q   <= {drive_hist_q[1:0], o_thermal_alarm_pin_oe};
        end
    end

    // Configuration register; bits 6 and 7 act on write and read back zero
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cfg_q <= `MCI_RST_CFG1;
        end else if (do_init) begin
            cfg_q <= `MCI_RST_CFG1;
        end else begin
            if (wr_cfg) begin
                cfg_q[`MCI_CFG_START]    <= i_reg_wdata[`MCI_CFG_START];
                cfg_q[`MCI_CFG_INT_EN]   <= i_reg_wdata[`MCI_CFG_INT_EN];
                cfg_q[`MCI_CFG_THERMAL_ALARM_PIN_EN] <= i_reg_wdata[`MCI_CFG_THERMAL_ALARM_PIN_EN];
                cfg_q[`MCI_CFG_INT_CLR]  <= i_reg_wdata[`MCI_CFG_INT_CLR];
                cfg_q[`MCI_CFG_RSVD]     <= i_reg_wdata[`MCI_CFG_RSVD];
            end
            cfg_q[`MCI_CFG_THERMAL_ALARM_PIN_REL] <= 1'b0;
            cfg_q[`MCI_CFG_INIT]      <= 1'b0;
            // Pulse bit stays set until the pulse has been output
            if (wr_cfg && i_reg_wdata[`MCI_CFG_RST_PULSE] && (rst_cnt_q == 24'h000000)) begin
                cfg_q[`MCI_CFG_RST_PULSE] <= 1'b1;
            end else if (rst_cnt_q == 24'h000001) begin
                cfg_q[`MCI_CFG_RST_PULSE] <= 1'b0;
            end
        end
    end

    // Reset pulse counter; a second write during a pulse is ignored
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_cnt_q     <= 24'h000000;
            o_reset_pin_n <= 1'b1;
        end else begin
            if (wr_cfg && i_reg_wdata[`MCI_CFG_RST_PULSE] && (rst_cnt_q == 24'h000000)) begin
                rst_cnt_q     <= RST_PULSE_CYC[23:0];
                o_reset_pin_n <= 1'b0;
            end else if (rst_cnt_q != 24'h000000) begin
                rst_cnt_q     <= rst_cnt_q - 24'h000001;
                o_reset_pin_n <= (rst_cnt_q == 24'h000001);
            end
        end
    end

    // Status and mask; a set arriving with a read-clear wins
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            stat1_q <= `MCI_RST_STAT1;
            stat2_q <= `MCI_RST_STAT2;
            mask1_q <= `MCI_RST_MASK1;
        end else if (do_init) begin
            stat1_q <= `MCI_RST_STAT1;
            stat2_q <= `MCI_RST_STAT2;
            mask1_q <= `MCI_RST_MASK1;
        end else begin
            stat1_q <= (stat1_q & ~({8{rd_stat1}} & stat1_q)) | ev1;
            stat2_q <= ((stat2_q & ~({8{rd_stat2}} & stat2_q)) | ev2) & `MCI_ST2_IMPL_MASK;
            if (wr_mask1) begin
                mask1_q <= i_reg_wdata;
            end
        end
    end

    // Read port: one cycle latency, unmapped addresses read zero
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_reg_rdata  <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                case (i_reg_addr)
                    `MCI_ADDR_CFG1:  o_reg_rdata <= cfg_q;
                    `MCI_ADDR_STAT1: o_reg_rdata <= stat1_q;
                    `MCI_ADDR_STAT2: o_reg_rdata <= stat2_q;
                    `MCI_ADDR_MASK1: o_reg_rdata <= mask1_q;
                    default:         o_reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // Interrupt output; start bit plays no part, so standby keeps it asserted
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_int_n <= 1'b1;
        end else begin
            o_int_n <= !(cfg_q[`MCI_CFG_INT_EN] && !cfg_q[`MCI_CFG_INT_CLR]
                         && (|(stat1_q & ~mask1_q) || |stat2_q));
        end
    end

    // Thermal alarm output, open drain; release write drops it, a live condition re-asserts
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_thermal_alarm_pin_o  <= 1'b0;
            o_thermal_alarm_pin_oe <= 1'b0;
        end else begin
            o_thermal_alarm_pin_o <= 1'b0;
            if (do_init || !cfg_q[`MCI_CFG_THERMAL_ALARM_PIN_EN]) begin
                o_thermal_alarm_pin_oe <= 1'b0;
            end else if (running && i_over_temp) begin
                o_thermal_alarm_pin_oe <= 1'b1;
            end else if (wr_cfg && i_reg_wdata[`MCI_CFG_THERMAL_ALARM_PIN_REL]) begin
                o_thermal_alarm_pin_oe <= 1'b0;
            end
        end
    end

    // Engine control
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_monitor_run <= 1'b0;
            o_init_pulse  <= 1'b0;
        end else begin
            o_monitor_run <= running && !do_init;
            o_init_pulse  <= do_init;
        end
    end

endmodule // mci_top

// *** verif/mci_checker.sv ***
// Assertions on the ports of the monitor control block.
// Assumes one clock domain; the pulse count is handed down by the bind.
module mci_checker #(parameter [31:0] RST_PULSE_CYC = 32'd20) (
    input wire logic       i_clk, i_rstn, i_reg_wr, i_reg_rd, i_over_temp,
    input wire logic [7:0] i_reg_addr, i_reg_wdata,
    input wire logic       o_reg_rvalid, o_monitor_run, o_init_pulse, o_int_n, o_reset_pin_n,
    input wire logic       o_thermal_alarm_pin_o, o_thermal_alarm_pin_oe
);
    logic [31:0] low_q;
    wire cfg_wr = i_reg_wr && i_reg_addr == 8'h40 && !i_reg_wdata[7];
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    // Low clocks of the reset pulse, exact count checked on its rise
    always @(posedge i_clk or negedge i_rstn)
        if (!i_rstn) low_q <= 32'h0;
        else low_q <= o_reset_pin_n ? 32'h0 : low_q + 32'h1;
    a_read_answered: assert property (i_reg_rd |=> o_reg_rvalid)
        else $error("read not answered");
    a_run_follows_cfg: assert property (cfg_wr ##2 1'b1 |-> o_monitor_run == (($past(i_reg_wdata, 2) & 8'h09) == 8'h01))
        else $error("monitor run wrong");
    a_int_disabled: assert property (cfg_wr && !i_reg_wdata[1] |-> ##2 o_int_n)
        else $error("interrupt not gated");
    a_int_cleared: assert property (cfg_wr && i_reg_wdata[3] |-> ##2 o_int_n [*2])
        else $error("interrupt not cleared");
    a_rst_pulse_start: assert property (cfg_wr && i_reg_wdata[4] && o_reset_pin_n |=> !o_reset_pin_n)
        else $error("reset pulse missing");
    a_rst_pulse_len: assert property ($rose(o_reset_pin_n) |-> low_q == RST_PULSE_CYC)
        else $error("reset pulse length wrong");
    a_init_one_shot: assert property (i_reg_wr && i_reg_addr == 8'h40 && i_reg_wdata[7] |=> o_init_pulse ##1 !o_init_pulse)
        else $error("init pulse wrong");
    a_thermal_alarm_pin_open_drain: assert property (!o_thermal_alarm_pin_o)
        else $error("alarm pin driven high");
    a_thermal_alarm_pin_released: assert property (cfg_wr && i_reg_wdata[6] && !i_over_temp ##1 !i_over_temp |=> !o_thermal_alarm_pin_oe)
        else $error("alarm not released");
endmodule // mci_checker

bind mci_top mci_checker #(.RST_PULSE_CYC(RST_PULSE_CYC)) u_checker (.*);

// *** verif/mci_host.sv ***
// Host model: register accesses as the serial bus engine makes them.
// Assumes strobes taken at the rising edge and read data one clock later.
module mci_host (
    input  wire logic       i_clk, i_rvalid,
    input  wire logic [7:0] i_rdata,
    output logic            o_wr = 1'b0, o_rd = 1'b0,
    output logic [7:0]      o_addr = 8'h00, o_wdata = 8'h00
);
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        o_addr = a;
        o_wdata = d;
        o_wr = 1'b1;
        @(negedge i_clk);
        o_wr = 1'b0;
        o_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_clk);
        o_addr = a;
        o_rd = 1'b1;
        @(negedge i_clk);
        o_rd = 1'b0;
        d = i_rvalid ? i_rdata : 8'hxx;
    endtask
endmodule // mci_host

// *** verif/tb_monitor_control_and_irq_status.sv ***
// Self-checking bench of the monitor control and status block.
// Assumes a short reset pulse count and a pulled-up alarm wire.
module tb_monitor_control_and_irq_status;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 0, i_rstn = 0, i_reg_wr, i_reg_rd, o_reg_rvalid, o_monitor_run, o_init_pulse, ext_n = 1;
    logic o_thermal_alarm_pin_o, o_thermal_alarm_pin_oe, o_int_n, o_reset_pin_n, i_over_temp = 0, i_chassis_pin = 0;
    logic i_limit_12v = 0, i_limit_core_voltage_two = 0, i_diode_one_fault = 0, i_diode_two_fault = 0;
    logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, i_limit_one = 0, v;
    logic [1:0] i_temp_event = 0;
    int error_cnt = 0, checks = 0;
    // Columns: limit events, temp events, mask, status read, interrupt level
    logic [7:0] rows [5][5] = '{'{8'h01, 8'h0, 8'h00, 8'h01, 8'h0}, '{8'h80, 8'h0, 8'h00, 8'h80, 8'h0},
        '{8'h10, 8'h0, 8'h10, 8'h10, 8'h1}, '{8'h24, 8'h0, 8'h04, 8'h24, 8'h0}, '{8'h00, 8'h3, 8'h00, 8'h30, 8'h0}};
    logic [7:0] rst_exp [5] = '{8'h08, 8'h00, 8'h00, 8'h00, 8'h00};
    wire i_thermal_alarm_pin_i = ext_n & ~o_thermal_alarm_pin_oe;
    always #2 i_clk = ~i_clk;
    mci_top #(.RST_PULSE_CYC(32'd20)) dut (.*);
    mci_host host (.i_clk(i_clk), .i_rvalid(o_reg_rvalid), .i_rdata(o_reg_rdata), .o_wr(i_reg_wr),
        .o_rd(i_reg_rd), .o_addr(i_reg_addr), .o_wdata(i_reg_wdata));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, v);
        chk(v, e);
    endtask
    task automatic ev(input logic [7:0] b, input logic [7:0] t);
        @(negedge i_clk);
        i_limit_one = b;
        i_temp_event = t[1:0];
        @(negedge i_clk);
        i_limit_one = 8'h00;
        i_temp_event = 2'h0;
        repeat (3) @(negedge i_clk);
    endtask
    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge i_clk);
        i_rstn = 1;
        foreach (rst_exp[i]) rchk(8'h40 + i[7:0], rst_exp[i]);
        host.wr(8'h41, 8'hff);
        rchk(8'h41, 8'h00);
        host.wr(8'h40, 8'h01); // No limit registers in this block
        ev(8'h01, 8'h0);
        chk({7'h0, o_int_n}, 8'h01);
        host.wr(8'h40, 8'h03);
        repeat (2) @(negedge i_clk);
        chk({7'h0, o_int_n}, 8'h00);
        host.wr(8'h40, 8'h02);
        repeat (2) @(negedge i_clk);
        chk({7'h0, o_int_n}, 8'h00);
        host.wr(8'h40, 8'h0a);
        repeat (2) @(negedge i_clk);
        chk({7'h0, o_int_n, o_monitor_run}, 8'h02);
        rchk(8'h41, 8'h01);
        host.wr(8'h40, 8'h03);
        repeat (2) @(negedge i_clk);
        chk({7'h0, o_monitor_run}, 8'h01);
        $display("Control tests done");
        foreach (rows[i]) begin
            host.wr(8'h43, rows[i][2]);
            ev(rows[i][0], rows[i][1]);
            chk({7'h0, o_int_n}, rows[i][4]);
            rchk(8'h41, rows[i][3]);
            rchk(8'h41, 8'h00);
            repeat (2) @(negedge i_clk);
            chk({7'h0, o_int_n}, 8'h01);
            $display("Row %0d done", i);
        end
        i_limit_one = 8'h02;
        rchk(8'h41, 8'h02);
        rchk(8'h41, 8'h02);
        i_limit_one = 8'h00;
        host.rd(8'h41, v);
        rchk(8'h41, 8'h00);
        @(negedge i_clk);
        {i_limit_12v, i_limit_core_voltage_two, i_diode_one_fault, i_diode_two_fault} = 4'hf;
        i_chassis_pin = 1;
        ext_n = 0;
        @(negedge i_clk);
        {i_limit_12v, i_limit_core_voltage_two, i_diode_one_fault, i_diode_two_fault} = 4'h0;
        repeat (6) @(negedge i_clk);
        ext_n = 1;
        repeat (4) @(negedge i_clk);
        chk({7'h0, o_int_n}, 8'h00);
        rchk(8'h42, 8'hf3);
        rchk(8'h42, 8'h00);
        $display("Status two test done");
        host.wr(8'h40, 8'h13);
        chk({7'h0, o_reset_pin_n}, 8'h00);
        rchk(8'h40, 8'h13);
        repeat (25) @(negedge i_clk);
        chk({7'h0, o_reset_pin_n}, 8'h01);
        rchk(8'h40, 8'h03);
        host.wr(8'h40, 8'h07);
        i_over_temp = 1;
        repeat (3) @(negedge i_clk);
        chk({7'h0, o_thermal_alarm_pin_oe}, 8'h01);
        i_over_temp = 0;
        host.wr(8'h40, 8'h47);
        repeat (2) @(negedge i_clk);
        chk({7'h0, o_thermal_alarm_pin_oe}, 8'h00);
        rchk(8'h40, 8'h07);
        host.wr(8'h43, 8'h55);
        host.wr(8'h40, 8'h80);
        rchk(8'h40, 8'h08);
        rchk(8'h43, 8'h00);
        $display("Pulse and init tests done");
        // Reset in the middle of a pulse must end it and restore defaults
        host.wr(8'h40, 8'h13);
        @(negedge i_clk);
        i_rstn = 0;
        repeat (3) @(negedge i_clk);
        chk({6'h0, o_reset_pin_n, o_int_n}, 8'h03);
        chk({7'h0, o_monitor_run}, 8'h00);
        i_rstn = 1;
        rchk(8'h40, 8'h08);
        repeat (25) @(negedge i_clk);
        chk({7'h0, o_reset_pin_n}, 8'h01);
        $display("Mid-run reset test done");
        complete_run();
    end
    initial begin
        repeat (5000) @(posedge i_clk);
        error_cnt++;
        complete_run();
    end
endmodule // tb_monitor_control_and_irq_status
